// [core/bsfo_pkg.sv]
/*
 * Shared types and constants of the bit, shift and flag execution unit:
 * operation codes, the request and result carriers, flag positions,
 * reset values and cycle counts.
 * Assumes a single 8-bit core datapath on one clock.
 */
package bsfo_pkg;

    // Data path width
    localparam int unsigned BSFO_DATA_W = 8;

    // Flag positions inside the status_flags_register
    localparam int unsigned BSFO_FLAG_C = 0;   // Carry
    localparam int unsigned BSFO_FLAG_Z = 1;   // Zero
    localparam int unsigned BSFO_FLAG_N = 2;   // Negative
    localparam int unsigned BSFO_FLAG_V = 3;   // Two's-complement overflow
    localparam int unsigned BSFO_FLAG_S = 4;   // Signed test
    localparam int unsigned BSFO_FLAG_H = 5;   // Half carry
    localparam int unsigned BSFO_FLAG_T = 6;   // Bit transfer
    localparam int unsigned BSFO_FLAG_I = 7;   // Global interrupt enable

    // Values after reset
    localparam logic [7:0] BSFO_FLAGS_RST = 8'h00;
    localparam logic [7:0] BSFO_DATA_RST  = 8'h00;

    // Execution length in clock cycles
    localparam int unsigned BSFO_CYC_SHORT = 1;
    localparam int unsigned BSFO_CYC_LONG  = 2;

    // Operations the unit executes
    typedef enum logic [4:0] {
        BSFO_OP_PUSH,
        BSFO_OP_POP,
        BSFO_OP_IO_BIT_SET,
        BSFO_OP_IO_BIT_CLEAR,
        BSFO_OP_SHIFT_LEFT_LOGICAL,
        BSFO_OP_SHIFT_RIGHT_LOGICAL,
        BSFO_OP_ROTATE_LEFT_VIA_CARRY,
        BSFO_OP_ROTATE_RIGHT_VIA_CARRY,
        BSFO_OP_ARITH_SHIFT_RIGHT,
        BSFO_OP_NIBBLE_SWAP,
        BSFO_OP_COPY_BIT_TO_TRANSFER_FLAG,
        BSFO_OP_LOAD_BIT_FROM_TRANSFER_FLAG,
        BSFO_OP_CARRY_SET,
        BSFO_OP_CARRY_CLEAR,
        BSFO_OP_NEGATIVE_SET,
        BSFO_OP_NEGATIVE_CLEAR,
        BSFO_OP_SIGN_SET,
        BSFO_OP_SIGN_CLEAR,
        BSFO_OP_OVERFLOW_SET,
        BSFO_OP_OVERFLOW_CLEAR,
        BSFO_OP_ZERO_SET,
        BSFO_OP_ZERO_CLEAR
    } bsfo_op_t;

    // One request: operation, operand byte, bit select
    typedef struct packed {
        bsfo_op_t   op;
        logic [7:0] operand;
        logic [2:0] bit_sel;
    } bsfo_req_t;

    // One result: byte and where it must be written
    typedef struct packed {
        logic [7:0] data;
        logic       reg_wr;
        logic       io_wr;
        logic       stack_wr;
    } bsfo_res_t;

endpackage

// [core/bsfo_unit.sv]
/*
 * Bit, shift and flag execution unit of an 8-bit core. Holds the
 * status_flags_register and executes one request at a time.
 * Assumes the register file, I/O space and stack sit outside: the
 * caller supplies the operand byte (register, I/O register or top of
 * stack) with the request and stores the result the unit hands back.
 */
// Function
// RULE1: Push takes two cycles, flags unchanged
// RULE2: Pop returns stack byte, two cycles, no flags
// RULE3: io_bit_set forces bit one, two cycles
// RULE4: io_bit_clear forces bit zero, two cycles
// RULE5: shift_left_logical inserts zero, updates Z C N V
// RULE6: shift_right_logical inserts zero, updates Z C N V
// RULE7: rotate_left_via_carry through carry, one cycle
// RULE8: rotate_right_via_carry through carry, one cycle
// RULE9: arith_shift_right keeps bit 7, updates flags
// RULE10: copy_bit_to_transfer_flag changes only T
// RULE11: load_bit_from_transfer_flag writes T, flags unchanged
// RULE12: Carry set and clear touch only carry
// RULE13: Negative set and clear, one cycle only
// RULE14: Sign flag set and clear, one cycle
// RULE15: Overflow flag set and clear, one cycle
// RULE16: Nibble swap exchanges halves, flags unchanged
// RULE17: Zero flag set and clear, one cycle
`timescale 1ns/1ps
`default_nettype none

module bsfo_unit
    import bsfo_pkg::*;
(
    // Clock, reset, enable
    input  wire logic      clock_in,
    input  wire logic      rst_in,
    input  wire logic      clk_en_in,
    // Request side
    input  wire logic      req_valid_in,
    input  wire bsfo_req_t req_in,
    output var  logic      ready_out,
    // Result side
    output var  logic      done_out,
    output var  bsfo_res_t res_out,
    // Status flags
    output var  logic [7:0] flags_out
);

    default clocking a_core_cb @(posedge clock_in); // Assertion clock
    endclocking
    default disable iff (rst_in);                   // Quiet in reset

    // Execution states
    typedef enum logic [0:0] {
        BSFO_ST_IDLE,
        BSFO_ST_BUSY
    } bsfo_state_t;

    bsfo_state_t state_q;      // Current state
    bsfo_state_t state_d;      // Next state
    logic [7:0]  flags_q;      // status_flags_register
    logic [7:0]  flags_d;
    bsfo_res_t   res_q;        // Result handed out
    bsfo_res_t   res_d;
    bsfo_res_t   pend_q;       // Result held over the second cycle
    bsfo_res_t   pend_d;
    logic        done_q;       // Result valid pulse
    logic        done_d;
    logic        ready_q;      // Request may be taken
    logic        ready_d;
    logic        accept;       // Request taken this edge

    // Force one flag to a value, leaving the rest alone
    function automatic logic [7:0] flag_put(input logic [7:0] f,
                                            input int unsigned pos,
                                            input logic v);
        logic [7:0] r;
        r      = f;
        r[pos] = v;
        return r;
    endfunction

    // Flags after a shift or rotate: Z, C, N and V; S and the
    // upper flags keep their value
    function automatic logic [7:0] shift_flags(input logic [7:0] f,
                                               input logic [7:0] res,
                                               input logic c);
        logic [7:0] r;
        r              = f;
        r[BSFO_FLAG_C] = c;
        r[BSFO_FLAG_Z] = (res == 8'h00);
        r[BSFO_FLAG_N] = res[7];
        r[BSFO_FLAG_V] = res[7] ^ c;
        return r;
    endfunction

    // Pack a result with its destination strobes
    function automatic bsfo_res_t mk_res(input logic [7:0] d,
                                         input logic rw,
                                         input logic iw,
                                         input logic sw);
        bsfo_res_t r;
        r.data     = d;
        r.reg_wr   = rw;
        r.io_wr    = iw;
        r.stack_wr = sw;
        return r;
    endfunction

    assign accept = clk_en_in && req_valid_in && ready_q;

    // Next-value logic: decode, compute result and flags
    always_comb
    begin
        logic [7:0] v;
        logic       c;
        v       = req_in.operand;
        c       = flags_q[BSFO_FLAG_C];
        state_d = state_q;
        flags_d = flags_q;
        res_d   = res_q;
        pend_d  = pend_q;
        done_d  = 1'b0;
        ready_d = ready_q;
        if (state_q == BSFO_ST_BUSY)
        begin
            // Second cycle of a long operation: release result
            res_d   = pend_q;
            done_d  = 1'b1;
            state_d = BSFO_ST_IDLE;
            ready_d = 1'b1;
        end
        else if (accept)
        begin
            // Short operations finish at this edge by default
            done_d = 1'b1;
            unique case (req_in.op)
                BSFO_OP_PUSH:
                begin
                    // Operand goes onto the stack; flags kept
                    pend_d  = mk_res(v, 1'b0, 1'b0, 1'b1); // RULE1
                    done_d  = 1'b0;
                    state_d = BSFO_ST_BUSY;
                    ready_d = 1'b0;
                end
                BSFO_OP_POP:
                begin
                    // Top stack byte goes to the destination
                    pend_d  = mk_res(v, 1'b1, 1'b0, 1'b0); // RULE2
                    done_d  = 1'b0;
                    state_d = BSFO_ST_BUSY;
                    ready_d = 1'b0;
                end
                BSFO_OP_IO_BIT_SET:
                begin
                    // Read-modify-write of the I/O byte
                    v[req_in.bit_sel] = 1'b1;
                    pend_d  = mk_res(v, 1'b0, 1'b1, 1'b0); // RULE3
                    done_d  = 1'b0;
                    state_d = BSFO_ST_BUSY;
                    ready_d = 1'b0;
                end
                BSFO_OP_IO_BIT_CLEAR:
                begin
                    v[req_in.bit_sel] = 1'b0;
                    pend_d  = mk_res(v, 1'b0, 1'b1, 1'b0); // RULE4
                    done_d  = 1'b0;
                    state_d = BSFO_ST_BUSY;
                    ready_d = 1'b0;
                end
                BSFO_OP_SHIFT_LEFT_LOGICAL:
                begin
                    res_d   = mk_res({v[6:0], 1'b0}, 1'b1, 1'b0,
                                     1'b0); // RULE5
                    flags_d = shift_flags(flags_q, res_d.data, v[7]);
                end
                BSFO_OP_SHIFT_RIGHT_LOGICAL:
                begin
                    res_d   = mk_res({1'b0, v[7:1]}, 1'b1, 1'b0,
                                     1'b0); // RULE6
                    flags_d = shift_flags(flags_q, res_d.data, v[0]);
                end
                BSFO_OP_ROTATE_LEFT_VIA_CARRY:
                begin
                    // Old carry enters at the bottom
                    res_d   = mk_res({v[6:0], c}, 1'b1, 1'b0,
                                     1'b0); // RULE7
                    flags_d = shift_flags(flags_q, res_d.data, v[7]);
                end
                BSFO_OP_ROTATE_RIGHT_VIA_CARRY:
                begin
                    // Old carry enters at the top
                    res_d   = mk_res({c, v[7:1]}, 1'b1, 1'b0,
                                     1'b0); // RULE8
                    flags_d = shift_flags(flags_q, res_d.data, v[0]);
                end
                BSFO_OP_ARITH_SHIFT_RIGHT:
                begin
                    // Sign bit is replicated, bit 0 drops into carry
                    res_d   = mk_res({v[7], v[7:1]}, 1'b1, 1'b0,
                                     1'b0); // RULE9
                    flags_d = shift_flags(flags_q, res_d.data, v[0]);
                end
                BSFO_OP_NIBBLE_SWAP:
                begin
                    res_d = mk_res({v[3:0], v[7:4]}, 1'b1, 1'b0,
                                   1'b0); // RULE16
                end
                BSFO_OP_COPY_BIT_TO_TRANSFER_FLAG:
                begin
                    // No byte is written back
                    res_d   = mk_res(v, 1'b0, 1'b0, 1'b0);
                    flags_d = flag_put(flags_q, BSFO_FLAG_T,
                                       v[req_in.bit_sel]); // RULE10
                end
                BSFO_OP_LOAD_BIT_FROM_TRANSFER_FLAG:
                begin
                    v[req_in.bit_sel] = flags_q[BSFO_FLAG_T];
                    res_d = mk_res(v, 1'b1, 1'b0, 1'b0); // RULE11
                end
                BSFO_OP_CARRY_SET, BSFO_OP_CARRY_CLEAR:
                begin
                    res_d   = mk_res(v, 1'b0, 1'b0, 1'b0);
                    flags_d = flag_put(flags_q, BSFO_FLAG_C,
                        req_in.op == BSFO_OP_CARRY_SET); // RULE12
                end
                BSFO_OP_NEGATIVE_SET, BSFO_OP_NEGATIVE_CLEAR:
                begin
                    res_d   = mk_res(v, 1'b0, 1'b0, 1'b0);
                    flags_d = flag_put(flags_q, BSFO_FLAG_N,
                        req_in.op == BSFO_OP_NEGATIVE_SET); // RULE13
                end
                BSFO_OP_SIGN_SET, BSFO_OP_SIGN_CLEAR:
                begin
                    res_d   = mk_res(v, 1'b0, 1'b0, 1'b0);
                    flags_d = flag_put(flags_q, BSFO_FLAG_S,
                        req_in.op == BSFO_OP_SIGN_SET); // RULE14
                end
                BSFO_OP_OVERFLOW_SET, BSFO_OP_OVERFLOW_CLEAR:
                begin
                    res_d   = mk_res(v, 1'b0, 1'b0, 1'b0);
                    flags_d = flag_put(flags_q, BSFO_FLAG_V,
                        req_in.op == BSFO_OP_OVERFLOW_SET); // RULE15
                end
                BSFO_OP_ZERO_SET, BSFO_OP_ZERO_CLEAR:
                begin
                    res_d   = mk_res(v, 1'b0, 1'b0, 1'b0);
                    flags_d = flag_put(flags_q, BSFO_FLAG_Z,
                        req_in.op == BSFO_OP_ZERO_SET); // RULE17
                end
                default:
                begin
                    // Illegal code: finish as a no-op, nothing written
                    res_d = mk_res(v, 1'b0, 1'b0, 1'b0);
                end
            endcase
        end
    end

    // State registers; enable low freezes everything
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            state_q <= BSFO_ST_IDLE;
            flags_q <= BSFO_FLAGS_RST;
            res_q   <= '0;
            pend_q  <= '0;
            done_q  <= 1'b0;
            ready_q <= 1'b1;
        end
        else if (clk_en_in)
        begin
            state_q <= state_d;
            flags_q <= flags_d;
            res_q   <= res_d;
            pend_q  <= pend_d;
            done_q  <= done_d;
            ready_q <= ready_d;
        end
    end

    // Outputs straight from flops
    assign ready_out = ready_q;
    assign done_out  = done_q;
    assign res_out   = res_q;
    assign flags_out = flags_q;

    // Checks
    a_push_two_cycles: assert property ( // RULE1
        (accept && req_in.op == BSFO_OP_PUSH) ##1 clk_en_in
        |=> done_out && res_out.stack_wr && flags_out == $past(flags_out, 2))
        else $error("push timing or flags wrong");

    a_pop_no_early: assert property ( // RULE2
        (accept && req_in.op == BSFO_OP_POP)
        |=> !done_out && !ready_out)
        else $error("pop finished too early");

    a_io_set_bit: assert property ( // RULE3
        (accept && req_in.op == BSFO_OP_IO_BIT_SET) ##1 clk_en_in
        |=> res_out.io_wr && res_out.data[$past(req_in.bit_sel, 2)])
        else $error("io bit set wrong");

    a_shl_result: assert property ( // RULE5
        (accept && req_in.op == BSFO_OP_SHIFT_LEFT_LOGICAL)
        |=> done_out && res_out.data == {$past(req_in.operand[6:0]), 1'b0}
            && flags_out[BSFO_FLAG_C] == $past(req_in.operand[7]))
        else $error("shift left result wrong");

    a_rotr_carry: assert property ( // RULE8
        (accept && req_in.op == BSFO_OP_ROTATE_RIGHT_VIA_CARRY)
        |=> res_out.data[7] == $past(flags_out[BSFO_FLAG_C])
            && flags_out[BSFO_FLAG_C] == $past(req_in.operand[0]))
        else $error("rotate right carry wrong");

    a_ashift_sign: assert property ( // RULE9
        (accept && req_in.op == BSFO_OP_ARITH_SHIFT_RIGHT)
        |=> res_out.data[7:6] == {2{$past(req_in.operand[7])}})
        else $error("arith shift sign lost");

    a_bit_copy_flags: assert property ( // RULE10
        (accept && req_in.op == BSFO_OP_COPY_BIT_TO_TRANSFER_FLAG)
        |=> flags_out == {$past(flags_out[7]),
            $past(req_in.operand[req_in.bit_sel]), $past(flags_out[5:0])})
        else $error("bit copy touched other flags");

    a_swap_flags: assert property ( // RULE16
        (accept && req_in.op == BSFO_OP_NIBBLE_SWAP)
        |=> flags_out == $past(flags_out)
            && res_out.data == {$past(req_in.operand[3:0]),
                                $past(req_in.operand[7:4])})
        else $error("nibble swap wrong");

    a_carry_set: assert property ( // RULE12
        (accept && req_in.op == BSFO_OP_CARRY_SET)
        |=> flags_out == ($past(flags_out) | 8'h01))
        else $error("carry set wrong");

endmodule

`default_nettype wire

// [tb/bsfo_unit_tb.sv]
/*
 * Self-checking bench for the bit, shift and flag unit: a reference
 * model, one request task and a scripted list of operations.
 * Assumes the unit alone, driven at the falling edge, 10 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module bsfo_unit_tb
    import bsfo_pkg::*;
;
    // Expected outcome of one request
    typedef struct packed {
        logic       long_op;
        logic       chk_d;
        logic [2:0] str;
        logic [7:0] data;
        logic [7:0] flags;
    } bsfo_exp_t;

    logic       clock_in;      // Core clock
    logic       rst_in;        // Synchronous reset
    logic       clk_en_in;     // Clock enable
    logic       req_valid_in;  // Request present
    bsfo_req_t  req_in;        // Request carrier
    logic       ready_out;     // Unit can take a request
    logic       done_out;      // Result valid pulse
    bsfo_res_t  res_out;       // Result carrier
    logic [7:0] flags_out;     // Status flags
    logic [7:0] exp_flags;     // Flags as the bench expects them
    int         failures;      // Mismatch count
    int         num_checks;    // Comparison count

    bsfo_unit u_bsfo_unit (
        .clock_in     (clock_in),
        .rst_in       (rst_in),
        .clk_en_in    (clk_en_in),
        .req_valid_in (req_valid_in),
        .req_in       (req_in),
        .ready_out    (ready_out),
        .done_out     (done_out),
        .res_out      (res_out),
        .flags_out    (flags_out)
    );

    // 100 ns period clock
    initial
    begin
        clock_in = 1'h0;
        forever #50 clock_in = ~clock_in;
    end

    // Reference behaviour, kept apart from the design on purpose
    function automatic bsfo_exp_t model(input bsfo_op_t op,
        input logic [7:0] d, input logic [2:0] b, input logic [7:0] f);
        bsfo_exp_t  e;
        logic [7:0] r;
        logic       c;
        logic       sh;
        e = '{1'h0, 1'h1, 3'h0, d, f};
        r = d;
        c = f[0];
        sh = 1'h0;
        case (op)
            BSFO_OP_PUSH:                        e.str = 3'h1;
            BSFO_OP_POP:                         e.str = 3'h4;
            BSFO_OP_IO_BIT_SET:                  r[b] = 1'h1;
            BSFO_OP_IO_BIT_CLEAR:                r[b] = 1'h0;
            BSFO_OP_SHIFT_LEFT_LOGICAL:          {c, r} = {d, 1'h0};
            BSFO_OP_SHIFT_RIGHT_LOGICAL:         {r, c} = {1'h0, d};
            BSFO_OP_ROTATE_LEFT_VIA_CARRY:       {c, r} = {d, f[0]};
            BSFO_OP_ROTATE_RIGHT_VIA_CARRY:      {r, c} = {f[0], d};
            BSFO_OP_ARITH_SHIFT_RIGHT:           {r, c} = {d[7], d};
            BSFO_OP_NIBBLE_SWAP:                 r = {d[3:0], d[7:4]};
            BSFO_OP_COPY_BIT_TO_TRANSFER_FLAG:   e.flags[6] = d[b];
            BSFO_OP_LOAD_BIT_FROM_TRANSFER_FLAG: r[b] = f[6];
            BSFO_OP_CARRY_SET:                   e.flags[0] = 1'h1;
            BSFO_OP_CARRY_CLEAR:                 e.flags[0] = 1'h0;
            BSFO_OP_ZERO_SET:                    e.flags[1] = 1'h1;
            BSFO_OP_ZERO_CLEAR:                  e.flags[1] = 1'h0;
            BSFO_OP_NEGATIVE_SET:                e.flags[2] = 1'h1;
            BSFO_OP_NEGATIVE_CLEAR:              e.flags[2] = 1'h0;
            BSFO_OP_OVERFLOW_SET:                e.flags[3] = 1'h1;
            BSFO_OP_OVERFLOW_CLEAR:              e.flags[3] = 1'h0;
            BSFO_OP_SIGN_SET:                    e.flags[4] = 1'h1;
            BSFO_OP_SIGN_CLEAR:                  e.flags[4] = 1'h0;
            default:                             e.chk_d = 1'h0;
        endcase
        // Writers to the register file
        if (op inside {BSFO_OP_SHIFT_LEFT_LOGICAL, BSFO_OP_SHIFT_RIGHT_LOGICAL,
            BSFO_OP_ROTATE_LEFT_VIA_CARRY, BSFO_OP_ROTATE_RIGHT_VIA_CARRY,
            BSFO_OP_ARITH_SHIFT_RIGHT})
            sh = 1'h1;
        if (sh || op == BSFO_OP_NIBBLE_SWAP
            || op == BSFO_OP_LOAD_BIT_FROM_TRANSFER_FLAG)
            e.str = 3'h4;
        // I/O bit ops write back to the I/O space
        if (op == BSFO_OP_IO_BIT_SET || op == BSFO_OP_IO_BIT_CLEAR)
            e.str = 3'h2;
        e.long_op = op inside {BSFO_OP_PUSH, BSFO_OP_POP,
            BSFO_OP_IO_BIT_SET, BSFO_OP_IO_BIT_CLEAR};
        // Shift family: Z C N V, overflow is N xor C
        if (sh)
            e.flags[3:0] = {r[7] ^ c, r[7], r == 8'h00, c};
        e.data = r;
        return e;
    endfunction

    // Byte results and flags
    task automatic check_byte(input string nm, input logic [7:0] ex,
        input logic [7:0] sn);
        num_checks++;
        if (sn !== ex)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, ex, sn);
        end
    endtask

    // Single handshake bits
    task automatic check_bit(input string nm, input logic ex,
        input logic sn);
        num_checks++;
        if (sn !== ex)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, ex, sn);
        end
    endtask

    // Cycle counts measured by the bench
    task automatic check_num(input string nm, input int ex, input int sn);
        num_checks++;
        if (sn != ex)
        begin
            failures++;
            $display("[ERR] %s expected %0d seen %0d", nm, ex, sn);
        end
    endtask

    // One request, then result, strobes, latency and flags
    task automatic run_op(input bsfo_op_t op, input logic [7:0] d,
        input logic [2:0] b);
        bsfo_exp_t e;
        int        n;
        e = model(op, d, b, exp_flags);
        @(negedge clock_in);
        check_bit("done_out pulse", 1'h0, done_out);
        check_bit("ready_out idle", 1'h1, ready_out);
        req_in = '{op: op, operand: d, bit_sel: b};
        req_valid_in = 1'h1;
        @(negedge clock_in);
        req_valid_in = 1'h0;
        n = 1;
        // Second cycle of a long op refuses requests
        if (e.long_op)
            check_bit("ready_out busy", 1'h0, ready_out);
        while (done_out !== 1'h1 && n < 4)
        begin
            @(negedge clock_in);
            n++;
        end
        check_num("cycles", e.long_op ? BSFO_CYC_LONG : BSFO_CYC_SHORT, n);
        check_bit("done_out", 1'h1, done_out);
        if (e.chk_d)
            check_byte("res data", e.data, res_out.data);
        check_byte("strobes", {5'h00, e.str},
            {5'h00, res_out.reg_wr, res_out.io_wr, res_out.stack_wr});
        check_byte("flags_out", e.flags, flags_out);
        exp_flags = e.flags;
    endtask

    // Counts, verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog: the script needs well under 400 cycles
    initial
    begin
        repeat (5000) @(posedge clock_in);
        failures++;
        report_and_stop();
    end

    // Main script
    initial
    begin
        failures = 0;
        num_checks = 0;
        exp_flags = 8'h00;
        rst_in = 1'h1;
        clk_en_in = 1'h1;
        req_valid_in = 1'h0;
        req_in = '0;
        repeat (20) @(negedge clock_in);
        rst_in = 1'h0;
        check_byte("reset flags", 8'h00, flags_out);
        // Every single-flag set, each leaving the others alone
        run_op(BSFO_OP_CARRY_SET, 8'h11, 3'h0);
        run_op(BSFO_OP_NEGATIVE_SET, 8'h22, 3'h0);
        run_op(BSFO_OP_SIGN_SET, 8'h33, 3'h0);
        run_op(BSFO_OP_OVERFLOW_SET, 8'h44, 3'h0);
        run_op(BSFO_OP_ZERO_SET, 8'h55, 3'h0);
        // Long ops and nibble swap with C Z N V S up, none may move
        run_op(BSFO_OP_PUSH, 8'h5a, 3'h0);
        run_op(BSFO_OP_POP, 8'ha5, 3'h0);
        run_op(BSFO_OP_IO_BIT_SET, 8'h00, 3'h7);
        run_op(BSFO_OP_IO_BIT_CLEAR, 8'hff, 3'h0);
        run_op(BSFO_OP_NIBBLE_SWAP, 8'h3c, 3'h0);
        // Transfer flag round trips, one and zero
        run_op(BSFO_OP_COPY_BIT_TO_TRANSFER_FLAG, 8'h10, 3'h4);
        run_op(BSFO_OP_LOAD_BIT_FROM_TRANSFER_FLAG, 8'h00, 3'h2);
        run_op(BSFO_OP_COPY_BIT_TO_TRANSFER_FLAG, 8'hef, 3'h4);
        run_op(BSFO_OP_LOAD_BIT_FROM_TRANSFER_FLAG, 8'hff, 3'h7);
        // Every single-flag clear
        run_op(BSFO_OP_CARRY_CLEAR, 8'h66, 3'h0);
        run_op(BSFO_OP_NEGATIVE_CLEAR, 8'h77, 3'h0);
        run_op(BSFO_OP_SIGN_CLEAR, 8'h88, 3'h0);
        run_op(BSFO_OP_OVERFLOW_CLEAR, 8'h99, 3'h0);
        run_op(BSFO_OP_ZERO_CLEAR, 8'haa, 3'h0);
        // Shifts and rotates, edge bits and zero results
        run_op(BSFO_OP_SHIFT_LEFT_LOGICAL, 8'h81, 3'h0);
        run_op(BSFO_OP_SHIFT_LEFT_LOGICAL, 8'h00, 3'h0);
        run_op(BSFO_OP_ROTATE_LEFT_VIA_CARRY, 8'h80, 3'h0);
        run_op(BSFO_OP_ROTATE_LEFT_VIA_CARRY, 8'h41, 3'h0);
        run_op(BSFO_OP_ROTATE_RIGHT_VIA_CARRY, 8'h01, 3'h0);
        run_op(BSFO_OP_ROTATE_RIGHT_VIA_CARRY, 8'h82, 3'h0);
        run_op(BSFO_OP_SHIFT_RIGHT_LOGICAL, 8'h01, 3'h0);
        run_op(BSFO_OP_SHIFT_RIGHT_LOGICAL, 8'hfe, 3'h0);
        run_op(BSFO_OP_ARITH_SHIFT_RIGHT, 8'h81, 3'h0);
        run_op(BSFO_OP_ARITH_SHIFT_RIGHT, 8'h7e, 3'h0);
        // Unused code: one cycle, no strobe, flags kept
        run_op(bsfo_op_t'(5'h1f), 8'h12, 3'h0);
        // Disabled clock holds a pending flag op back
        @(negedge clock_in);
        clk_en_in = 1'h0;
        req_in = '{op: BSFO_OP_CARRY_SET, operand: 8'h00, bit_sel: 3'h0};
        req_valid_in = 1'h1;
        repeat (3) @(negedge clock_in);
        check_byte("frozen flags", exp_flags, flags_out);
        clk_en_in = 1'h1;
        @(negedge clock_in);
        req_valid_in = 1'h0;
        check_byte("enabled flags", exp_flags | 8'h01, flags_out);
        // Second reset in mid-run clears the flags
        rst_in = 1'h1;
        repeat (2) @(negedge clock_in);
        rst_in = 1'h0;
        exp_flags = 8'h00;
        check_byte("re-reset flags", 8'h00, flags_out);
        run_op(BSFO_OP_PUSH, 8'hc3, 3'h0);
        report_and_stop();
    end
endmodule

`default_nettype wire
